/* File: shared/backlight_pkg.sv */
package backlight_pkg;
	// register offsets
	localparam logic [7:0] ADDR_LED_CONTROL      = 8'h00;
	localparam logic [7:0] ADDR_BANK_CONFIG      = 8'h01;
	localparam logic [7:0] ADDR_BOOST_CONTROL    = 8'h02;
	localparam logic [7:0] ADDR_BRIGHTNESS_A     = 8'h03;
	localparam logic [7:0] ADDR_BRIGHTNESS_B     = 8'h04;
	localparam logic [7:0] ADDR_FS_CURRENT_A     = 8'h05;
	localparam logic [7:0] ADDR_FS_CURRENT_B     = 8'h06;
	localparam logic [7:0] ADDR_FILTER_STRENGTH  = 8'h50;
	// reset values
	localparam logic [7:0] RST_ZERO              = 8'h00;
	// bank configuration fields
	localparam int CFG_PWM_A_BIT                 = 0;
	localparam int CFG_PWM_B_BIT                 = 1;
	localparam int CFG_FB_A_BIT                  = 3;
	localparam int CFG_FB_B_BIT                  = 4;
	// boost control fields
	localparam int BOOST_FREQ_BIT                = 0;
	localparam int BOOST_OCL_LSB                 = 3;
	localparam int BOOST_OCL_MSB                 = 4;
	localparam int BOOST_OVL_LSB                 = 5;
	localparam int BOOST_OVL_MSB                 = 6;
	// full-scale current fields
	localparam int FS_CODE_MSB                   = 4;
	localparam int FS_HYST_BIT                   = 7;
	localparam int FS_LOWB_BIT                   = 6;
	localparam logic [1:0] HYST_TWO_CODES        = 2'h2;
	localparam logic [1:0] HYST_ONE_CODE         = 2'h1;
	localparam logic [3:0] LOWB_CODE_SIX         = 4'h6;
	localparam logic [3:0] LOWB_CODE_ALT         = 4'h0;
	// control fields
	localparam int CTL_EN_B_BIT                  = 3;
	localparam int CTL_EN_A_BIT                  = 2;
	localparam int CTL_LINEAR_BIT                = 4;
	// filter strength field width
	localparam int FILTER_MSB                    = 1;
	// two-wire bus
	localparam logic [6:0] SLAVE_ADDR            = 7'h36;
	typedef enum logic [1:0] {FREQ_500K, FREQ_1M} boost_freq_t;
endpackage

/* File: rtl/pin_sync.sv */
`timescale 1ns/100ps
module pin_sync #(
	parameter int           W = 1
) (
	input  wire logic         ref_clk, // core clock
	input  wire logic         arst_n,  // async reset
	input  wire logic [W-1:0] d,       // async input
	output logic      [W-1:0] q        // synchronised level
);
	logic [W-1:0] meta_r;

	// idle bus level is high
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= '1;
			q      <= '1;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

/* File: rtl/backlight_regs.sv */
// Functional notes
// - config at 01h holds per-bank PWM/feedback enables; 09h enables bank A both.
// - boost control at 02h; 78h gives 40V limit, 1.2A limit, 500kHz.
// - boost frequency selectable between 500 kHz and 1 MHz.
// - full-scale current A at 05h, B at 06h; 14h gives 20 mA.
// - current A bit 7 set gives sampler hysteresis of two codes.
// - current A bit 6 clear gives sampler lower bound code six.
// - sampler settings in current A govern both banks.
// - control at 00h; 14h selects linear control and enables bank A.
// - brightness A at 03h, B at 04h scale bank currents.
`timescale 1ns/100ps
module backlight_regs (
	input  wire logic        ref_clk,           // 125 MHz core clock
	input  wire logic        arst_n,            // async reset, active low
	input  wire logic        scl_in,            // serial clock pin
	input  wire logic        sda_in,            // serial data pin level
	output logic             sda_out,           // serial data drive value
	output logic             sda_oe,            // serial data drive enable
	input  wire logic        pwm_in,            // brightness pwm pin
	output logic             pwm_en_a,          // bank a pwm enable
	output logic             pwm_en_b,          // bank b pwm enable
	output logic             fb_en_a,           // bank a feedback enable
	output logic             fb_en_b,           // bank b feedback enable
	output logic [1:0]       overvoltage_limit, // 16/24/32/40 V select
	output logic [1:0]       overcurrent_limit, // current limit select
	output logic             boost_freq_select, // 0: 500 kHz, 1: 1 MHz
	output logic             bank_en_a,         // bank a enable
	output logic             bank_en_b,         // bank b enable
	output logic             linear_mode,       // 1: linear, 0: exponential
	output logic [4:0]       fs_code_a,         // bank a full-scale code
	output logic [4:0]       fs_code_b,         // bank b full-scale code
	output logic [1:0]       sampler_hyst,      // sampler hysteresis, codes
	output logic [3:0]       sampler_lowb,      // sampler lower bound code
	output logic [1:0]       filter_strength,   // input filter strength
	output logic [7:0]       level_a,           // bank a brightness after pwm
	output logic [7:0]       level_b            // bank b brightness after pwm
);
	logic [7:0] led_control_r, bank_configuration_r, boost_control_r;
	logic [7:0] brightness_bank_a_r, brightness_bank_b_r;
	logic [7:0] full_scale_current_a_r, full_scale_current_b_r, input_filter_strength_r;

	logic scl_s, sda_s, pwm_s;
	pin_sync #(.W(3)) u_sync (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.d       ({scl_in, sda_in, pwm_in}),
		.q       ({scl_s, sda_s, pwm_s})
	);

	logic scl_d_r, sda_d_r;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
		end
	end
	logic scl_rise, scl_fall, start_c, stop_c;
	assign scl_rise = scl_s & ~scl_d_r;
	assign scl_fall = ~scl_s & scl_d_r;
	assign start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;

	// serial slave: address byte, register pointer, data bytes
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_PTR, S_DATA, S_READ, S_RACK}
		ser_state_t;
	ser_state_t st_r, st_nxt_after_ack_r;
	logic [3:0] bitcnt_r;
	logic [7:0] shift_r, ptr_r, rdata_r;
	logic       rw_r, have_ptr_r, ack_drive_r, wr_commit_r;
	logic [7:0] wr_addr_r, wr_data_r;

	logic [7:0] rd_mux;
	always_comb begin
		unique case (ptr_r)
			backlight_pkg::ADDR_LED_CONTROL:     rd_mux = led_control_r;
			backlight_pkg::ADDR_BANK_CONFIG:     rd_mux = bank_configuration_r;
			backlight_pkg::ADDR_BOOST_CONTROL:   rd_mux = boost_control_r;
			backlight_pkg::ADDR_BRIGHTNESS_A:    rd_mux = brightness_bank_a_r;
			backlight_pkg::ADDR_BRIGHTNESS_B:    rd_mux = brightness_bank_b_r;
			backlight_pkg::ADDR_FS_CURRENT_A:    rd_mux = full_scale_current_a_r;
			backlight_pkg::ADDR_FS_CURRENT_B:    rd_mux = full_scale_current_b_r;
			backlight_pkg::ADDR_FILTER_STRENGTH: rd_mux = input_filter_strength_r;
			default:                             rd_mux = backlight_pkg::RST_ZERO;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r               <= S_IDLE;
			st_nxt_after_ack_r <= S_IDLE;
			bitcnt_r           <= 4'h0;
			shift_r            <= 8'h00;
			ptr_r              <= 8'h00;
			rdata_r            <= 8'h00;
			rw_r               <= 1'b0;
			have_ptr_r         <= 1'b0;
			ack_drive_r        <= 1'b0;
			wr_commit_r        <= 1'b0;
			wr_addr_r          <= 8'h00;
			wr_data_r          <= 8'h00;
		end else begin
			wr_commit_r <= 1'b0;
			if (start_c) begin
				st_r        <= S_ADDR;
				bitcnt_r    <= 4'h0;
				ack_drive_r <= 1'b0;
			end else if (stop_c) begin
				st_r        <= S_IDLE;
				ack_drive_r <= 1'b0;
			end else begin
				unique case (st_r)
					S_IDLE: ;
					S_ADDR, S_PTR, S_DATA: begin
						if (scl_rise) begin
							shift_r  <= {shift_r[6:0], sda_s};
							bitcnt_r <= bitcnt_r + 4'h1;
						end
						if (scl_fall && bitcnt_r == 4'h8) begin
							bitcnt_r <= 4'h0;
							if (st_r == S_ADDR) begin
								if (shift_r[7:1] == backlight_pkg::SLAVE_ADDR) begin
									rw_r               <= shift_r[0];
									ack_drive_r        <= 1'b1;
									st_r               <= S_ACK;
									rdata_r            <= rd_mux;
									st_nxt_after_ack_r <= shift_r[0] ? S_READ : S_PTR;
								end else begin
									st_r <= S_IDLE;
								end
							end else if (st_r == S_PTR) begin
								ptr_r              <= shift_r;
								ack_drive_r        <= 1'b1;
								st_r               <= S_ACK;
								st_nxt_after_ack_r <= S_DATA;
							end else begin
								// byte is held until its ack clock ends
								wr_addr_r          <= ptr_r;
								wr_data_r          <= shift_r;
								ack_drive_r        <= 1'b1;
								st_r               <= S_ACK;
								st_nxt_after_ack_r <= S_DATA;
							end
						end
					end
					S_ACK: begin
						if (scl_fall) begin
							ack_drive_r <= 1'b0;
							st_r        <= st_nxt_after_ack_r;
							if (st_nxt_after_ack_r == S_DATA && have_ptr_r) begin
								wr_commit_r <= 1'b1;
								ptr_r       <= ptr_r + 8'h01;
							end
							have_ptr_r <= (st_nxt_after_ack_r == S_DATA);
							if (st_nxt_after_ack_r == S_READ) begin
								rdata_r <= rd_mux;
							end
						end
					end
					S_READ: begin
						if (scl_rise) begin
							bitcnt_r <= bitcnt_r + 4'h1;
						end
						if (scl_fall) begin
							if (bitcnt_r == 4'h8) begin
								bitcnt_r <= 4'h0;
								st_r     <= S_RACK;
								ptr_r    <= ptr_r + 8'h01;
							end else begin
								rdata_r <= {rdata_r[6:0], 1'b0};
							end
						end
					end
					S_RACK: begin
						// master nack ends the read; an ack waits for the fall so the
						// next byte never moves sda while scl is high
						if (scl_rise && sda_s) begin
							st_r <= S_IDLE;
						end
						if (scl_fall) begin
							st_r    <= S_READ;
							rdata_r <= rd_mux;
						end
					end
					default: st_r <= S_IDLE;
				endcase
			end
			if (start_c || stop_c || st_r == S_ADDR) begin
				have_ptr_r <= (st_r == S_ACK) ? have_ptr_r : 1'b0;
			end
		end
	end

	assign sda_oe  = ack_drive_r | (st_r == S_READ && !rdata_r[7]);
	assign sda_out = 1'b0;

	// register file, each data byte committed after its ack, pointer incrementing per byte
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			led_control_r           <= backlight_pkg::RST_ZERO;
			bank_configuration_r    <= backlight_pkg::RST_ZERO;
			boost_control_r         <= backlight_pkg::RST_ZERO;
			brightness_bank_a_r     <= backlight_pkg::RST_ZERO;
			brightness_bank_b_r     <= backlight_pkg::RST_ZERO;
			full_scale_current_a_r  <= backlight_pkg::RST_ZERO;
			full_scale_current_b_r  <= backlight_pkg::RST_ZERO;
			input_filter_strength_r <= backlight_pkg::RST_ZERO;
		end else if (wr_commit_r) begin
			unique case (wr_addr_r)
				backlight_pkg::ADDR_LED_CONTROL:     led_control_r <= wr_data_r;
				backlight_pkg::ADDR_BANK_CONFIG:     bank_configuration_r <= wr_data_r;
				backlight_pkg::ADDR_BOOST_CONTROL:   boost_control_r <= wr_data_r;
				backlight_pkg::ADDR_BRIGHTNESS_A:    brightness_bank_a_r <= wr_data_r;
				backlight_pkg::ADDR_BRIGHTNESS_B:    brightness_bank_b_r <= wr_data_r;
				backlight_pkg::ADDR_FS_CURRENT_A:    full_scale_current_a_r <= wr_data_r;
				backlight_pkg::ADDR_FS_CURRENT_B:    full_scale_current_b_r <= wr_data_r;
				backlight_pkg::ADDR_FILTER_STRENGTH: input_filter_strength_r <= wr_data_r;
				default: ;
			endcase
		end
	end

	// decoded settings
	assign pwm_en_a = bank_configuration_r[backlight_pkg::CFG_PWM_A_BIT];
	assign pwm_en_b = bank_configuration_r[backlight_pkg::CFG_PWM_B_BIT];
	assign fb_en_a  = bank_configuration_r[backlight_pkg::CFG_FB_A_BIT];
	assign fb_en_b  = bank_configuration_r[backlight_pkg::CFG_FB_B_BIT];
	assign overvoltage_limit =
		boost_control_r[backlight_pkg::BOOST_OVL_MSB:backlight_pkg::BOOST_OVL_LSB];
	assign overcurrent_limit =
		boost_control_r[backlight_pkg::BOOST_OCL_MSB:backlight_pkg::BOOST_OCL_LSB];
	assign boost_freq_select = boost_control_r[backlight_pkg::BOOST_FREQ_BIT];
	assign linear_mode = led_control_r[backlight_pkg::CTL_LINEAR_BIT];
	assign bank_en_a   = led_control_r[backlight_pkg::CTL_EN_A_BIT];
	assign bank_en_b   = led_control_r[backlight_pkg::CTL_EN_B_BIT];
	assign fs_code_a = full_scale_current_a_r[backlight_pkg::FS_CODE_MSB:0];
	assign fs_code_b = full_scale_current_b_r[backlight_pkg::FS_CODE_MSB:0];
	// sampler settings shared by both banks
	assign sampler_hyst = full_scale_current_a_r[backlight_pkg::FS_HYST_BIT] ?
		backlight_pkg::HYST_TWO_CODES : backlight_pkg::HYST_ONE_CODE;
	assign sampler_lowb = full_scale_current_a_r[backlight_pkg::FS_LOWB_BIT] ?
		backlight_pkg::LOWB_CODE_ALT : backlight_pkg::LOWB_CODE_SIX;
	assign filter_strength = input_filter_strength_r[backlight_pkg::FILTER_MSB:0];

	// pwm gating: a disabled bank, or a low pwm pin while that bank's pwm enable is set, forces zero
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			level_a <= 8'h00;
			level_b <= 8'h00;
		end else begin
			level_a <= (bank_en_a && (!pwm_en_a || pwm_s)) ? brightness_bank_a_r : 8'h00;
			level_b <= (bank_en_b && (!pwm_en_b || pwm_s)) ? brightness_bank_b_r : 8'h00;
		end
	end
endmodule

/* File: testbench/backlight_regs_monitor.sv */
`timescale 1ns/100ps
module backlight_regs_monitor (
	input wire logic       ref_clk,           // core clock
	input wire logic       arst_n,            // async reset
	input wire logic       scl_in,            // serial clock pin
	input wire logic       sda_out,           // data drive value
	input wire logic       sda_oe,            // data drive enable
	input wire logic       pwm_en_a,          // bank a pwm enable
	input wire logic       pwm_en_b,          // bank b pwm enable
	input wire logic       fb_en_a,           // bank a feedback enable
	input wire logic       fb_en_b,           // bank b feedback enable
	input wire logic [1:0] overvoltage_limit, // voltage limit select
	input wire logic [1:0] overcurrent_limit, // current limit select
	input wire logic       boost_freq_select, // boost frequency
	input wire logic [4:0] fs_code_a,         // bank a full scale
	input wire logic [1:0] sampler_hyst,      // sampler hysteresis
	input wire logic [3:0] sampler_lowb,      // sampler lower bound
	input wire logic       bank_en_a,         // bank a enable
	input wire logic       bank_en_b,         // bank b enable
	input wire logic [7:0] level_a,           // bank a level
	input wire logic [7:0] level_b            // bank b level
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// open drain: only ever pull low, and only move the drive while scl is low
	property p_sda_low; sda_out == 1'b0 && (!$changed(sda_oe) || !scl_in); endproperty
	a_sda_low: assert property (p_sda_low) else $error("sda driven high");
	// a commit lands four edges after the scl pin falls
	property p_hyst; (sampler_hyst == 2'h2 || sampler_hyst == 2'h1) &&
		(!$changed(sampler_hyst) || !$past(scl_in, 3)); endproperty
	a_hyst: assert property (p_hyst) else $error("bad hysteresis");
	property p_lowb; (sampler_lowb == 4'h6 || sampler_lowb == 4'h0) &&
		(!$changed(sampler_lowb) || !$past(scl_in, 3)); endproperty
	a_lowb: assert property (p_lowb) else $error("bad lower bound");
	property p_lvl_a; (!bank_en_a) [*3] |-> level_a == 8'h00; endproperty
	a_lvl_a: assert property (p_lvl_a) else $error("bank a lit while off");
	property p_lvl_b; (!bank_en_b) [*3] |-> level_b == 8'h00; endproperty
	a_lvl_b: assert property (p_lvl_b) else $error("bank b lit while off");
	// commits follow an scl fall, so a long high phase freezes registers
	property p_cfg; scl_in [*5] |-> $stable({pwm_en_a, pwm_en_b, fb_en_a, fb_en_b}); endproperty
	a_cfg: assert property (p_cfg) else $error("config moved without scl fall");
	property p_boost; scl_in [*5] |-> $stable({overvoltage_limit, overcurrent_limit,
		boost_freq_select, fs_code_a, sampler_hyst, sampler_lowb}); endproperty
	a_boost: assert property (p_boost) else $error("boost moved without scl fall");
	property p_oe; scl_in [*5] |-> $stable(sda_oe); endproperty
	a_oe: assert property (p_oe) else $error("sda changed while scl high");
endmodule
bind backlight_regs backlight_regs_monitor u_mon (.ref_clk(ref_clk), .arst_n(arst_n),
	.scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .pwm_en_a(pwm_en_a),
	.pwm_en_b(pwm_en_b), .fb_en_a(fb_en_a), .fb_en_b(fb_en_b),
	.overvoltage_limit(overvoltage_limit), .overcurrent_limit(overcurrent_limit),
	.boost_freq_select(boost_freq_select), .fs_code_a(fs_code_a),
	.sampler_hyst(sampler_hyst), .sampler_lowb(sampler_lowb), .bank_en_a(bank_en_a),
	.bank_en_b(bank_en_b), .level_a(level_a), .level_b(level_b));

/* File: testbench/i2c_host_model.sv */
`timescale 1ns/100ps
module i2c_host_model (
	input  wire logic ref_clk, // core clock
	input  wire logic sda,     // resolved data wire
	output logic      scl,     // serial clock, idles high
	output logic      sda_low  // 1 pulls data low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// six-cycle phases keep well above the three-cycle minimum
	task automatic step(input logic c, input logic d);
		@(posedge ref_clk);
		scl <= c;
		sda_low <= !d;
		repeat (5) @(posedge ref_clk);
	endtask
	task automatic bit_out(input logic d);
		step(1'b0, !sda_low);
		step(1'b0, d);
		step(1'b1, d);
	endtask
	task automatic send(input logic [7:0] v, inout logic ok);
		for (int i = 7; i >= 0; i--)
			bit_out(v[i]);
		bit_out(1'b1);
		ok = ok & !sda;
	endtask
	// last high sends nack, low sends ack after the byte
	task automatic get(input logic last, output logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			bit_out(1'b1);
			v[i] = sda;
		end
		bit_out(last);
	endtask
	// pointer write, repeated start, two bytes read back
	task automatic read_pair(input logic [6:0] a, input logic [7:0] p,
		output logic [7:0] d0, output logic [7:0] d1, output logic ok);
		ok = 1'b1;
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		send({a, 1'b0}, ok);
		send(p, ok);
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		send({a, 1'b1}, ok);
		get(1'b0, d0);
		get(1'b1, d1);
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask
	task automatic write(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
		output logic ok);
		ok = 1'b1;
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		send({a, 1'b0}, ok);
		send(p, ok);
		send(d, ok);
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask
endmodule

/* File: testbench/test_backlight_regs.sv */
`timescale 1ns/100ps
module test_backlight_regs;
	logic       ref_clk    = 1'b0;
	logic       arst_n     = 1'b0;
	logic       pwm        = 1'b1;
	logic       h_scl, h_low, ok, sdo, oe, pea, peb, fea, feb, bf, ena, enb, lin;
	logic [1:0] ovl, ocl, hy, flt;
	logic [4:0] fsa, fsb;
	logic [3:0] lb;
	logic [7:0] la, lvb, rd0, rd1;
	wire logic  sda_w;
	int         m [256];
	int         r;
	int         mismatches = 0;
	int         tests_run  = 0;
	assign sda_w = !(h_low || (oe && !sdo));
	always #4 ref_clk = !ref_clk;
	i2c_host_model u_host (.ref_clk(ref_clk), .sda(sda_w), .scl(h_scl), .sda_low(h_low));
	backlight_regs u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .scl_in(h_scl), .sda_in(sda_w),
		.sda_out(sdo), .sda_oe(oe), .pwm_in(pwm), .pwm_en_a(pea), .pwm_en_b(peb),
		.fb_en_a(fea), .fb_en_b(feb), .overvoltage_limit(ovl), .overcurrent_limit(ocl),
		.boost_freq_select(bf), .bank_en_a(ena), .bank_en_b(enb), .linear_mode(lin),
		.fs_code_a(fsa), .fs_code_b(fsb), .sampler_hyst(hy), .sampler_lowb(lb),
		.filter_strength(flt), .level_a(la), .level_b(lvb));
	task automatic chk(input string n, input logic [45:0] e, input logic [45:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	function automatic logic [7:0] lv(input logic en, input logic pe, input int br);
		return (en && !(pe && !pwm)) ? br[7:0] : 8'h00;
	endfunction
	task automatic cmp();
		logic [7:0] c, b, t, f;
		c = m[1];
		b = m[2];
		t = m[0];
		f = m[5];
		chk("outputs", {c[0], c[1], c[3], c[4], b[6:5], b[4:3], b[0], t[2], t[3], t[4], f[4:0],
			m[6][4:0], f[7] ? 2'h2 : 2'h1, f[6] ? 4'h0 : 4'h6, m[80][1:0],
			lv(t[2], c[0], m[3]), lv(t[3], c[1], m[4])}, {pea, peb, fea, feb, ovl, ocl, bf,
			ena, enb, lin, fsa, fsb, hy, lb, flt, la, lvb});
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic [6:0] a = 7'h36);
		u_host.write(a, p, d, ok);
		chk("ack", {45'h0, a == 7'h36}, {45'h0, ok});
		if (a == 7'h36 && (p <= 8'h06 || p == 8'h50))
			m[p] = d;
		repeat (10) @(posedge ref_clk);
		cmp();
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge ref_clk);
		mismatches++;
		summarize();
	end
	initial begin
		r = $urandom(32'h63a3);
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		cmp();
		wr(8'h50, 8'h03);
		wr(8'h01, 8'h09);
		wr(8'h02, 8'h78);
		wr(8'h05, 8'h94);
		wr(8'h06, 8'h0a);
		wr(8'h00, 8'h14);
		wr(8'h03, 8'hff);
		pwm <= 1'b0;
		repeat (10) @(posedge ref_clk);
		cmp();
		wr(8'h02, 8'h79);
		wr(8'h05, 8'h54);
		wr(8'h01, 8'h5a, 7'h37);
		wr(8'h07, 8'h5a);
		wr(8'h00, 8'h1c);
		for (int i = 0; i < 8; i++) begin
			pwm <= 1'($urandom);
			wr(8'($urandom_range(6)), 8'($urandom));
		end
		u_host.read_pair(7'h36, 8'h05, rd0, rd1, ok);
		chk("read 05", {29'h0, 1'b1, m[5][7:0], m[6][7:0]}, {29'h0, ok, rd0, rd1});
		u_host.read_pair(7'h36, 8'h50, rd0, rd1, ok);
		chk("read 50", {29'h0, 1'b1, m[80][7:0], 8'h00}, {29'h0, ok, rd0, rd1});
		arst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		m = '{default: 0};
		repeat (3) @(posedge ref_clk);
		cmp();
		summarize();
	end
endmodule
